// >>> pkg/flt_pkg.sv
// Constants for the fastlock timeout control word decoder.
// Assumes a single system clock and a comparison clock event strobe.
package flt_pkg;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned CSR_HI      = 23;
  localparam int unsigned CSR_LO      = 22;
  localparam int unsigned CPF_HI      = 21;
  localparam int unsigned CPF_LO      = 18;
  localparam int unsigned TOC_HI      = 17;
  localparam int unsigned TOC_LO      = 4;
  localparam int unsigned SEL_HI      = 3;
  localparam int unsigned SEL_LO      = 0;
  localparam int unsigned TOC_W       = 14;
  localparam int unsigned CNT_W       = 15;
  localparam int unsigned CPF_W       = 4;
  localparam int unsigned MULT_W      = 5;
  localparam int unsigned CSR_W       = 2;
  localparam int unsigned DIV_W       = 5;
  localparam logic [3:0]  SEL_CODE    = 4'hD;

  // ****************************************
  // Timeout count codes
  // ****************************************
  localparam logic [TOC_W-1:0] TOC_HIZ    = 14'h0000;
  localparam logic [TOC_W-1:0] TOC_MANUAL = 14'h0001;
  localparam logic [TOC_W-1:0] TOC_LOW    = 14'h0002;
  localparam logic [TOC_W-1:0] TOC_HIGH   = 14'h0003;
  localparam logic [TOC_W-1:0] TOC_TIMED  = 14'h0004;

  // ****************************************
  // Slip reduction rate divisors (1, 2, 4, 16)
  // ****************************************
  localparam logic [DIV_W-1:0] DIV_OFF = 5'h01;
  localparam logic [DIV_W-1:0] DIV_2   = 5'h02;
  localparam logic [DIV_W-1:0] DIV_4   = 5'h04;
  localparam logic [DIV_W-1:0] DIV_16  = 5'h10;

  localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 15'h0001;

  typedef enum logic [1:0] {
    FLT_IDLE  = 2'b00,
    FLT_TIMED = 2'b01,
    FLT_DONE  = 2'b11,
    FLT_GPO   = 2'b10
  } flt_state_type;

endpackage

// >>> logic/flt_timer.sv
// Fastlock period counter, loaded with twice the timeout count.
// Assumes comparison clock events arrive as one-cycle enable pulses.
`timescale 1ns/1ps
module flt_timer (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic                     load,
  input  wire logic [flt_pkg::TOC_W-1:0] toc,
  input  wire logic                     cmp_evt,
  output logic                          running
);
  import flt_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  wire  [CNT_W-1:0] load_val = {toc, 1'b0};

  // Load wins over counting so a rewrite restarts the period
  assign next_cnt = load ? load_val :
                    (cmp_evt && cnt != CNT_ZERO) ? cnt - CNT_ONE : cnt;
  assign running  = (cnt != CNT_ZERO);

  // Countdown register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= CNT_ZERO;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Exactly 2*toc events from load to idle
  a_load_value: assert property (@(posedge sys_clk) disable iff (!arst_n)
    load |=> cnt == $past(load_val)) else $error("period load wrong");
  a_count_step: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!load && cmp_evt && running) |=> cnt == $past(cnt) - CNT_ONE) else $error("count step wrong");
  a_hold_still: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!load && !cmp_evt) |=> $stable(cnt)) else $error("count moved");
endmodule

// >>> logic/flt_ctrl.sv
// Fastlock timeout control word decoder and fastlock pin driver.
// Assumes a parallel 24-bit word with a one-cycle write strobe and
// comparison clock events as one-cycle pulses on sys_clk.
`timescale 1ns/1ps
module flt_ctrl (
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire logic [flt_pkg::WORD_W-1:0]  cfg_word,
  input  wire logic                        cfg_wr,
  input  wire logic                        cmp_evt,
  output logic                             fast_active,
  output logic [flt_pkg::MULT_W-1:0]       pump_mult,
  output logic                             slip_en,
  output logic [flt_pkg::DIV_W-1:0]        slip_div,
  output logic                             fast_out_pin_o,
  output logic                             fast_out_pin_oe,
  output flt_pkg::flt_state_type           state
);
  import flt_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [DIV_W-1:0] slip_divisor(input logic [CSR_W-1:0] sel);
    logic [DIV_W-1:0] d;
    d = DIV_OFF;
    unique case (sel)
      2'b00: d = DIV_OFF;
      2'b01: d = DIV_2;
      2'b10: d = DIV_4;
      2'b11: d = DIV_16;
    endcase
    return d;
  endfunction

  // ****************************************
  // Stored word fields
  // ****************************************
  logic [CSR_W-1:0] slip_reduce_sel;
  logic [CPF_W-1:0] fast_pump_current;
  logic [TOC_W-1:0] fast_timeout_count;
  flt_state_type    next_state;
  logic             timer_run;

  // Words with a foreign select code belong to other registers
  wire              word_hit   = cfg_wr && (cfg_word[SEL_HI:SEL_LO] == SEL_CODE);
  wire [TOC_W-1:0]  wr_toc     = cfg_word[TOC_HI:TOC_LO];
  wire              wr_timed   = wr_toc >= TOC_TIMED;
  wire              timer_load = word_hit && wr_timed;
  wire              is_manual  = fast_timeout_count == TOC_MANUAL;
  wire              is_timed   = fast_timeout_count >= TOC_TIMED;

  // Field capture, reset leaves fastlock off and pin floating
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slip_reduce_sel    <= '0;
      fast_pump_current  <= '0;
      fast_timeout_count <= TOC_HIZ;
    end else if (word_hit) begin
      slip_reduce_sel    <= cfg_word[CSR_HI:CSR_LO];
      fast_pump_current  <= cfg_word[CPF_HI:CPF_LO];
      fast_timeout_count <= wr_toc;
    end
  end

  flt_timer u_timer (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .load    (timer_load),
    .toc     (wr_toc),
    .cmp_evt (cmp_evt),
    .running (timer_run)
  );

  // ****************************************
  // Mode state
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      FLT_IDLE, FLT_GPO, FLT_DONE: begin
        if (timer_load) next_state = FLT_TIMED;
        else if (word_hit) next_state = FLT_GPO;
      end
      FLT_TIMED: begin
        if (timer_load) next_state = FLT_TIMED;
        else if (word_hit) next_state = FLT_GPO;
        else if (!timer_run) next_state = FLT_DONE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= FLT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs to charge pump and pin
  // ****************************************
  // Fastlock is a level held by manual mode or the running period
  wire next_active = (state == FLT_TIMED && timer_run && is_timed) || is_manual;

  // Pin drive: timed mode indicates fastlock, manual mode active low output
  wire next_pin_oe = fast_timeout_count != TOC_HIZ;
  wire next_pin_o  = is_timed ? next_active :
                     (fast_timeout_count == TOC_HIGH);

  // Registered data outputs; pump multiplier is code plus one
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fast_active     <= 1'b0;
      pump_mult       <= '0;
      slip_en         <= 1'b0;
      slip_div        <= DIV_OFF;
      fast_out_pin_o  <= 1'b0;
      fast_out_pin_oe <= 1'b0;
    end else begin
      fast_active     <= next_active;
      pump_mult       <= {1'b0, fast_pump_current} + MULT_W'(1);
      slip_en         <= slip_reduce_sel != '0;
      slip_div        <= slip_divisor(slip_reduce_sel);
      fast_out_pin_o  <= next_pin_o;
      fast_out_pin_oe <= next_pin_oe;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_gpo_no_fast: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (fast_timeout_count != TOC_MANUAL && !is_timed) |=> !fast_active) else $error("fastlock in GPO");
  a_pin_levels: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (fast_timeout_count == TOC_HIGH) |=> fast_out_pin_oe && fast_out_pin_o) else $error("pin not high");
  a_pin_hiz: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (fast_timeout_count == TOC_HIZ) |=> !fast_out_pin_oe) else $error("pin not floating");
  a_manual_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_manual |=> fast_active && fast_out_pin_oe && !fast_out_pin_o) else $error("manual wrong");
  a_timed_start: assert property (@(posedge sys_clk) disable iff (!arst_n)
    timer_load |=> ##1 fast_active && fast_out_pin_o) else $error("timed not started");
  a_timed_end: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == FLT_TIMED && !timer_run && !word_hit) |=> state == FLT_DONE ##1 !fast_active)
    else $error("timed not ended");
  a_pump_step: assert property (@(posedge sys_clk) disable iff (!arst_n)
    word_hit |=> ##1 pump_mult == MULT_W'($past(cfg_word[CPF_HI:CPF_LO], 2)) + MULT_W'(1))
    else $error("pump step wrong");
  a_slip_div: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (word_hit && cfg_word[CSR_HI:CSR_LO] == 2'b11) |=> ##1 slip_en && slip_div == DIV_16)
    else $error("slip divisor wrong");
  // Low level in general-purpose mode must still be driven, not floated
  a_pin_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (fast_timeout_count == TOC_LOW) |=> fast_out_pin_oe && !fast_out_pin_o) else $error("pin not low");
  // In timed mode the pin mirrors the fastlock condition
  a_timed_pin: assert property (@(posedge sys_clk) disable iff (!arst_n)
    is_timed |=> fast_out_pin_oe && (fast_out_pin_o == fast_active)) else $error("pin not fastlock");
  a_foreign_word: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cfg_wr && !word_hit) |=> $stable(fast_timeout_count)) else $error("foreign word taken");

  c_timed_run: cover property (@(posedge sys_clk) disable iff (!arst_n) state == FLT_TIMED ##1 state == FLT_DONE);
  c_restart:   cover property (@(posedge sys_clk) disable iff (!arst_n) state == FLT_TIMED && timer_load);
  c_manual:    cover property (@(posedge sys_clk) disable iff (!arst_n) is_manual && fast_active);
  c_gpo_low:   cover property (@(posedge sys_clk) disable iff (!arst_n)
    fast_timeout_count == TOC_LOW && fast_out_pin_oe && !fast_out_pin_o);
endmodule

// >>> dv/flt_host.sv
// Host model that writes fastlock control words to the decoder.
// Assumes the bench calls send() from its main sequence.
`timescale 1ns/1ps
module flt_host (
  input  wire logic                       sys_clk,
  output logic [flt_pkg::WORD_W-1:0]      cfg_word,
  output logic                            cfg_wr
);
  import flt_pkg::*;

  // Idle bus before the first word
  initial begin
    cfg_word = 24'h000000;
    cfg_wr   = 1'b0;
  end

  // One word per strobe; the released bus shows the inverse, never a stale copy
  task automatic send(input logic [1:0] slip, input logic [3:0] code, input logic [13:0] toc,
                      input logic [3:0] sel);
    @(posedge sys_clk);
    cfg_word <= {slip, code, toc, sel};
    cfg_wr   <= 1'b1;
    @(posedge sys_clk);
    cfg_word <= ~{slip, code, toc, sel};
    cfg_wr   <= 1'b0;
  endtask
endmodule

// >>> dv/fastlock_timeout_control_tb.sv
// Self-checking bench for the fastlock control word decoder.
// Assumes flt_host drives the word port and the bench drives cmp_evt.
`timescale 1ns/1ps
module fastlock_timeout_control_tb;
  import flt_pkg::*;
  logic                sys_clk;
  logic                arst_n;
  logic                cmp_evt;
  logic                cfg_wr;
  logic                fast_active;
  logic                slip_en;
  logic                pin_o;
  logic                pin_oe;
  logic [WORD_W-1:0]   cfg_word;
  logic [MULT_W-1:0]   pump_mult;
  logic [DIV_W-1:0]    slip_div;
  flt_state_type       state;
  logic [1:0]          cur_slip;
  logic [3:0]          cur_code;
  logic [13:0]         cur_toc;
  logic [15:0]         exp_q[$];
  int                  n_errors = 0;
  int                  n_tests = 0;
  event                obs;

  flt_host i_host (.sys_clk(sys_clk), .cfg_word(cfg_word), .cfg_wr(cfg_wr));
  flt_ctrl i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .cfg_word(cfg_word), .cfg_wr(cfg_wr),
    .cmp_evt(cmp_evt), .fast_active(fast_active), .pump_mult(pump_mult), .slip_en(slip_en),
    .slip_div(slip_div), .fast_out_pin_o(pin_o), .fast_out_pin_oe(pin_oe), .state(state));

  // Expected outputs packed as {active, mult, slip on, divisor, pin, pin enable, state}
  function automatic logic [15:0] expv(input logic act);
    logic       fa;
    logic [4:0] dv;
    logic [1:0] st;
    fa = act | (cur_toc == 14'h0001);
    dv = (cur_slip == 2'h0) ? 5'h01 : (cur_slip == 2'h1) ? 5'h02 : (cur_slip == 2'h2) ? 5'h04 : 5'h10;
    st = (cur_toc > 14'h0003) ? (act ? FLT_TIMED : FLT_DONE) : FLT_GPO;
    return {fa, 5'(cur_code) + 5'h01, cur_slip != 2'h0, dv,
            (cur_toc == 14'h0003) | ((cur_toc > 14'h0003) & fa), cur_toc != 14'h0000, st};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH outputs expected %h seen %h", exp, seen);
    end
  endtask

  // Outputs settle one edge after the fields are stored
  task automatic expect_now(input logic act);
    @(posedge sys_clk);
    #1;
    exp_q.push_back(expv(act));
    ->obs;
  endtask

  task automatic wr(input logic [1:0] s, input logic [3:0] c, input logic [13:0] t, input logic act);
    i_host.send(s, c, t, SEL_CODE);
    cur_slip = s;
    cur_code = c;
    cur_toc  = t;
    expect_now(act);
  endtask

  // Pulses spaced apart; each count lands on the edge that ends its pulse, then one idle edge
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      cmp_evt <= 1'b1;
      @(posedge sys_clk);
      cmp_evt <= 1'b0;
    end
    @(posedge sys_clk);
  endtask

  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Pin value only counts while driven
  initial forever begin
    @(obs);
    check({fast_active, pump_mult, slip_en, slip_div, pin_o & pin_oe, pin_oe, state}, exp_q.pop_front());
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Longest case is 32766 pulses, about 66k cycles; give up at 80k
  initial begin
    #800us;
    n_errors++;
    complete_run();
  end

  initial begin
    int t;
    arst_n  = 1'b0;
    cmp_evt = 1'b0;
    void'($urandom(18));
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Every slip code, every pump code, every pin mode except timed
    for (int i = 0; i < 16; i++) wr(2'(i >> 2), 4'(i), 14'(i % 4), 1'b0);
    // Wrong select code must leave everything alone
    i_host.send(2'h0, 4'h0, 14'h0002, 4'hB);
    expect_now(1'b0);
    // Random short timed period
    t = 4 + $urandom % 4;
    wr(2'($urandom), 4'($urandom), 14'(t), 1'b1);
    pulse(2 * t - 1);
    expect_now(1'b1);
    pulse(1);
    expect_now(1'b0);
    // Rewrite mid-period restarts from the new count
    wr(2'($urandom), 4'($urandom), 14'h0005, 1'b1);
    pulse(6);
    wr(2'($urandom), 4'($urandom), 14'h0004, 1'b1);
    pulse(7);
    expect_now(1'b1);
    pulse(1);
    expect_now(1'b0);
    // A general-purpose word cuts a running period short
    wr(2'($urandom), 4'($urandom), 14'h0005, 1'b1);
    pulse(2);
    wr(2'($urandom), 4'($urandom), 14'h0002, 1'b0);
    // Manual mode ignores comparison events
    wr(2'($urandom), 4'($urandom), 14'h0001, 1'b0);
    pulse(20);
    expect_now(1'b0);
    // Largest count
    wr(2'($urandom), 4'($urandom), 14'h3FFF, 1'b1);
    pulse(32765);
    expect_now(1'b1);
    pulse(1);
    expect_now(1'b0);
    @(posedge sys_clk);
    complete_run();
  end
endmodule
